//--- dv/secc_core_assertions.sv
// Concurrent checks on the ports of the EEPROM command core.
// Assumes the host keeps the minimum serial pin spacing.
`default_nettype none
module secc_core_chk
  import secc_pkg::*;
#(
  parameter int unsigned WRITE_CYCLES_P = WRITE_CYCLES // Cycle length
) (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire secc_pins_t pins_i,
  input wire logic so_o,
  input wire logic so_oe_o,
  input wire logic busy_o
);
  timeunit 1ns;
  timeprecision 1ps;
  int unsigned busy_cnt_q; // Busy cycles seen so far
  int unsigned rise_cnt_q; // Raw clock rises since select fell
  logic sck_q; // Raw clock one cycle ago
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (reset_i);
  // Length of the running programming cycle
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      busy_cnt_q <= 0;
    end else begin
      busy_cnt_q <= busy_o ? busy_cnt_q + 1 : 0;
    end
  end
  // Raw edge count; the pins are not synchronised here on purpose
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      sck_q <= 1'b0;
      rise_cnt_q <= 0;
    end else begin
      sck_q <= pins_i.sck;
      rise_cnt_q <= pins_i.cs_n ? 0 : rise_cnt_q + 32'(pins_i.sck & ~sck_q);
    end
  end
  property p_desel_quiet;
    pins_i.cs_n [*5] |-> !so_oe_o;
  endproperty
  a_desel_quiet: assert property (p_desel_quiet)
    else $error("output driven while deselected");
  property p_pause_quiet;
    !pins_i.hold_n [*5] |-> !so_oe_o;
  endproperty
  a_pause_quiet: assert property (p_pause_quiet)
    else $error("output driven during pause");
  property p_fall_shift;
    so_oe_o && $changed(so_o) |-> !$past(pins_i.sck, 3);
  endproperty
  a_fall_shift: assert property (p_fall_shift)
    else $error("output bit moved outside a falling clock");
  property p_busy_max;
    busy_o |-> busy_cnt_q < WRITE_CYCLES_P + 2;
  endproperty
  a_busy_max: assert property (p_busy_max)
    else $error("programming cycle too long");
  property p_busy_min;
    $fell(busy_o) |-> busy_cnt_q + 2 >= WRITE_CYCLES_P;
  endproperty
  a_busy_min: assert property (p_busy_min)
    else $error("programming cycle cut short");
  property p_busy_start;
    $rose(busy_o) |-> pins_i.cs_n && !$past(pins_i.cs_n, 6);
  endproperty
  a_busy_start: assert property (p_busy_start)
    else $error("programming started without a select rise");
  property p_busy_hold;
    busy_o && busy_cnt_q + 3 < WRITE_CYCLES_P |=> busy_o;
  endproperty
  a_busy_hold: assert property (p_busy_hold)
    else $error("busy dropped early");
  property p_opcode_first;
    $rose(so_oe_o) |-> rise_cnt_q >= 8 && !pins_i.cs_n;
  endproperty
  a_opcode_first: assert property (p_opcode_first)
    else $error("output before a whole opcode");
  c_prog: cover property ($rose(busy_o));
  c_read: cover property ($rose(so_oe_o));
  c_pause: cover property (!pins_i.hold_n && !pins_i.cs_n);
endmodule : secc_core_chk
bind secc_core secc_core_chk #(.WRITE_CYCLES_P(WRITE_CYCLES_P)) u_chk (
  .clk_i(clk_i), .reset_i(reset_i), .pins_i(pins_i), .so_o(so_o),
  .so_oe_o(so_oe_o), .busy_o(busy_o));
`default_nettype wire

//--- dv/secc_host_model.sv
// Mode 0 SPI host that frames, shifts and pauses transfers.
// Assumes its tasks are entered at a rising system clock edge.
`default_nettype none
module secc_host_model
  import secc_pkg::*;
(
  input wire logic clk_i,
  input wire logic so_i, // Resolved serial out line
  output var secc_pins_t pins_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // Idle: deselected, clock low, guard pin high
  initial pins_o = '{sck: 0, cs_n: 1, si: 0, hold_n: 1, wp_n: 1};
  // Select fall opens a frame
  task automatic sel();
    pins_o.cs_n <= 1'b0;
    repeat (4) @(posedge clk_i);
  endtask : sel
  // Select rise closes it; the released data line flips
  task automatic desel();
    repeat (4) @(posedge clk_i);
    pins_o.cs_n <= 1'b1;
    pins_o.si <= ~pins_o.si;
    repeat (4) @(posedge clk_i);
  endtask : desel
  // Shifts n bits MSB first; 8 clk per bit, the fastest legal spacing
  task automatic xfer(input logic [7:0] tx, input int n,
                      output logic [7:0] rx);
    rx = 8'h00;
    for (int i = n - 1; i >= 0; i--) begin
      pins_o.si <= tx[i];
      repeat (4) @(posedge clk_i);
      pins_o.sck <= 1'b1;
      repeat (4) @(posedge clk_i);
      rx[i] = so_i;
      pins_o.sck <= 1'b0;
    end
  endtask : xfer
  // Pause input moves only while the clock is low
  // Settle the clock low first so a pending falling edge is not masked
  task automatic hold(input logic v);
    repeat (4) @(posedge clk_i);
    pins_o.hold_n <= v;
    repeat (6) @(posedge clk_i);
  endtask : hold
  task automatic set_wp(input logic v);
    pins_o.wp_n <= v;
    @(posedge clk_i);
  endtask : set_wp
endmodule : secc_host_model
`default_nettype wire

//--- dv/test_spi_eeprom_command_core.sv
// Self-checking bench of the EEPROM command core with a host model.
// Assumes a shortened write cycle so the run stays brief.
`default_nettype none
module test_spi_eeprom_command_core import secc_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int unsigned WCYC = 600; // Longer than one status read
  logic clk_i;
  logic reset_i;
  secc_pins_t pins;
  logic so, so_oe, busy, tog, oe_seen;
  wire logic so_w;
  int err_total, n_checks;
  // Released line shows a changing pattern, never the last bit
  assign so_w = so_oe ? so : tog;
  secc_core #(.WRITE_CYCLES_P(WCYC)) dut (.clk_i(clk_i), .reset_i(reset_i),
    .pins_i(pins), .so_o(so), .so_oe_o(so_oe), .busy_o(busy));
  secc_host_model host (.clk_i(clk_i), .so_i(so_w), .pins_o(pins));
  initial begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end
  // Line pattern and a record of any output drive
  always @(posedge clk_i) begin
    tog <= ~tog;
    if (so_oe === 1'b1) oe_seen <= 1'b1;
  end
  task automatic chk(input string what, input logic [7:0] seen, exp);
    n_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("unexpected %s: expected %h, seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic frame(input logic [7:0] tx[$], output logic [7:0] rx[$]);
    logic [7:0] r;
    rx = {};
    host.sel();
    foreach (tx[i]) begin
      host.xfer(tx[i], 8, r);
      rx.push_back(r);
    end
    host.desel();
  endtask : frame
  task automatic status(input logic [7:0] exp, input string what);
    logic [7:0] rx[$];
    frame({OP_RD_STATUS, 8'h00}, rx);
    chk(what, rx[1], exp);
  endtask : status
  // Bounded wait; the checker judges the exact length
  task automatic wait_ready();
    int k;
    k = 0;
    while (busy !== 1'b0 && k < WCYC + 200) begin
      @(posedge clk_i);
      k++;
    end
    chk("busy end", 8'(busy), 8'h00);
  endtask : wait_ready
  task automatic busy_is(input logic v, input string what);
    repeat (6) @(posedge clk_i);
    chk(what, 8'(busy), 8'(v));
  endtask : busy_is
  task automatic t_latch();
    logic [7:0] rx[$];
    logic [7:0] r;
    status(8'h00, "status after reset");
    frame({OP_SET_LATCH}, rx);
    status(8'h02, "latch set");
    frame({OP_CLR_LATCH}, rx);
    status(8'h00, "latch clear");
    host.sel();
    host.xfer(OP_SET_LATCH, 8, r);
    host.xfer(8'h00, 1, r);
    host.desel();
    status(8'h00, "latch with extra clock");
    oe_seen = 1'b0;
    frame({8'hff, 8'h00}, rx);
    chk("unknown opcode drive", 8'(oe_seen), 8'h00);
    $display("test latch done");
  endtask : t_latch
  task automatic t_array();
    logic [7:0] rx[$];
    frame({OP_WR_ARRAY, 8'h00, 8'h10, 8'h99}, rx);
    busy_is(1'b0, "write without latch");
    frame({OP_SET_LATCH}, rx);
    frame({OP_WR_ARRAY, 8'hff, 8'hff, 8'h5a, 8'ha5, 8'h3c}, rx);
    busy_is(1'b1, "busy after write");
    oe_seen = 1'b0;
    frame({OP_RD_ARRAY, 8'h1f, 8'hc0, 8'h00}, rx);
    chk("read while busy", 8'(oe_seen), 8'h00);
    status(8'h03, "status while busy");
    wait_ready();
    status(8'h00, "latch after cycle");
    frame({OP_SET_LATCH}, rx);
    frame({OP_WR_ARRAY, 8'h00, 8'h00, 8'h77}, rx);
    wait_ready();
    frame({OP_RD_ARRAY, 8'h1f, 8'hff, 8'h00, 8'h00}, rx);
    chk("top byte", rx[3], 8'h5a);
    chk("read wrap", rx[4], 8'h77);
    frame({OP_RD_ARRAY, 8'h1f, 8'hc0, 8'h00, 8'h00}, rx);
    chk("page wrap first", rx[3], 8'ha5);
    chk("page wrap next", rx[4], 8'h3c);
    $display("test array done");
  endtask : t_array
  task automatic t_guard();
    logic [7:0] rx[$];
    frame({OP_SET_LATCH}, rx);
    frame({OP_WR_STATUS, 8'hf4}, rx);
    wait_ready();
    status(8'h84, "status write");
    host.set_wp(1'b0);
    frame({OP_SET_LATCH}, rx);
    frame({OP_WR_STATUS, 8'h00}, rx);
    busy_is(1'b0, "pin guarded status");
    status(8'h86, "status kept");
    frame({OP_WR_ARRAY, 8'h18, 8'h00, 8'h11}, rx);
    busy_is(1'b0, "guarded quarter");
    frame({OP_WR_ARRAY, 8'h17, 8'hff, 8'h22}, rx);
    busy_is(1'b1, "free location");
    wait_ready();
    host.set_wp(1'b1);
    frame({OP_SET_LATCH}, rx);
    frame({OP_WR_STATUS, 8'h00}, rx);
    wait_ready();
    status(8'h00, "status unguarded");
    $display("test guard done");
  endtask : t_guard
  task automatic t_pause();
    logic [7:0] rx[$];
    logic [7:0] r;
    frame({OP_SET_LATCH}, rx);
    host.sel();
    host.xfer(OP_RD_STATUS, 8, r);
    host.xfer(8'h00, 3, r);
    chk("bits before pause", r, 8'h00);
    host.hold(1'b0);
    chk("drive in pause", 8'(so_oe), 8'h00);
    host.xfer(8'hff, 2, r);
    host.hold(1'b1);
    host.xfer(8'h00, 5, r);
    host.desel();
    chk("bits after pause", r, 8'h02);
    host.sel();
    host.xfer(OP_WR_ARRAY, 8, r);
    host.xfer(8'h00, 8, r);
    host.xfer(8'h20, 8, r);
    host.xfer(8'hff, 4, r);
    host.desel();
    busy_is(1'b0, "partial byte");
    status(8'h02, "latch after partial");
    $display("test pause done");
  endtask : t_pause
  task automatic print_verdict();
    $display("checks %0d, mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : print_verdict
  // Watchdog: several times the expected run length
  initial begin
    repeat (80000) @(posedge clk_i);
    err_total++;
    print_verdict();
  end
  initial begin
    err_total = 0;
    n_checks = 0;
    tog = 1'b0;
    oe_seen = 1'b0;
    reset_i = 1'b1;
    repeat (3) @(posedge clk_i);
    reset_i <= 1'b0;
    repeat (4) @(posedge clk_i);
    t_latch();
    t_array();
    t_guard();
    t_pause();
    print_verdict();
  end
endmodule : test_spi_eeprom_command_core
`default_nettype wire

//--- src/secc_core.sv
// Command, protection and write sequencing core of an 8K x 8 serial EEPROM
// slave with a 64-byte page buffer and a self-timed write cycle.
// Assumes all pins come from an SPI host outside the clock domain; they are
// synchronised here and the serial clock is found by edge detection, so the
// system clock must run well above four times the serial clock.
//
// Overview of operation
// - Sample serial input on rising clock edges
// - Shift serial output on falling clock edges
// - Deselected: output off, standby unless busy
// - First eight bits form opcode; others ignored
// - Decode latch set, latch clear, status read
// - Decode status write, array read, array write
// - Busy flag high during programming, read-only
// - Latch commands set or clear write latch
// - Block guard bits cleared by power-up reset
// - Guard bits select quarter, half, whole array
// - Guard pin and enable block status writes
// - Latch gates writes; status also pin gated
// - Write latch clear after power-up
// - Never program locations inside guarded range
// - Latch command commits only on clean end
// - Sixteen address bits, low thirteen used
// - Programming starts at select rise only
// - While busy only status read obeyed
// - Page load wraps inside the page
// - Programming end clears write latch
// - Pause: output off, input ignored
// - Programming finishes within five milliseconds
// - Array read advances and wraps address
// - Status write changes bits two, three, seven
`default_nettype none

module secc_core
  import secc_pkg::*;
#(
  parameter int unsigned WRITE_CYCLES_P = WRITE_CYCLES // Write cycle length
) (
  input wire logic clk_i, // System clock, 40 MHz
  input wire logic reset_i, // Power-up reset, active high
  input wire secc_pins_t pins_i, // Raw pin levels from the host
  output logic so_o, // Serial data out
  output logic so_oe_o, // Serial out driven when high
  output logic busy_o // Programming cycle in progress
);

  // A write cycle of no cycles cannot be timed
  if (WRITE_CYCLES_P < 1) begin : g_bad_cycles
    $error("secc_core: WRITE_CYCLES_P must be at least 1");
  end

  secc_pins_t pins_s; // Synchronised pin levels
  logic sck_prev_q; // Serial clock one cycle back
  logic cs_prev_q; // Select one cycle back
  logic selected; // Select low and no pause
  logic sck_rise; // Usable rising serial edge
  logic sck_fall; // Usable falling serial edge
  logic cs_rise; // Select released
  logic cs_fall; // Select asserted
  secc_phase_t phase_q; // Transaction phase
  logic [2:0] bit_cnt_q; // Bit position in the current byte
  logic [7:0] shift_q; // Input shift register
  logic [7:0] in_byte; // Byte completed by this edge
  logic byte_done; // Eighth bit arrives now
  logic [7:0] cmd_q; // Accepted opcode
  logic addr_hi_done_q; // First address byte received
  logic [15:0] addr_q; // Address pointer, top three bits unused
  logic have_byte_q; // At least one whole data byte taken
  logic [7:0] stat_data_q; // Byte offered by a status write
  logic [7:0] page_buf_q [PAGE_BYTES]; // Page buffer contents
  logic [PAGE_BYTES-1:0] page_valid_q; // Loaded page buffer slots
  logic [7:0] mem_q [2**ADDR_BITS]; // Array contents
  logic latch_q; // Write latch
  logic [1:0] guard_q; // Block guard bits
  logic pin_en_q; // Guard pin enable
  logic busy_q; // Programming cycle running
  logic prog_status_q; // Running cycle is a status write
  logic [ADDR_BITS-COL_BITS-1:0] prog_page_q; // Page being programmed
  logic [31:0] timer_q; // Programming cycle timer
  logic prog_end; // Last cycle of programming
  logic [7:0] status_rd; // Status as read by the host
  logic status_open; // Status register may be written
  logic page_guarded; // Addressed page lies in guarded range
  logic [7:0] out_src; // Byte to be shifted out next
  logic [7:0] out_shift_q; // Output shift register
  logic [2:0] out_cnt_q; // Output bit position
  logic out_started_q; // First output bit has been driven
  logic so_q; // Output data flop
  logic so_oe_q; // Output enable flop

  // Pins cross into the system clock through two flops
  secc_sync #(
    .WIDTH(5),
    .RESET_VAL(PINS_IDLE)
  ) u_pin_sync (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .d_i(pins_i),
    .q_o(pins_s)
  );

  // Edge history of serial clock and select
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      sck_prev_q <= 1'b0;
      cs_prev_q <= 1'b1;
    end else begin
      sck_prev_q <= pins_s.sck;
      cs_prev_q <= pins_s.cs_n;
    end
  end

  // Pause masks serial edges so nothing moves while held
  assign selected = ~pins_s.cs_n & pins_s.hold_n;
  assign sck_rise = selected & pins_s.sck & ~sck_prev_q;
  assign sck_fall = selected & ~pins_s.sck & sck_prev_q;
  assign cs_rise = pins_s.cs_n & ~cs_prev_q;
  assign cs_fall = ~pins_s.cs_n & cs_prev_q;
  assign in_byte = {shift_q[6:0], pins_s.si};
  assign byte_done = sck_rise & (bit_cnt_q == 3'h7);

  // Status image; unused bits read zero
  always_comb begin
    status_rd = 8'h00;
    status_rd[ST_BUSY_BIT] = busy_q;
    status_rd[ST_LATCH_BIT] = latch_q;
    status_rd[ST_GUARD_LO_BIT] = guard_q[0];
    status_rd[ST_GUARD_HI_BIT] = guard_q[1];
    status_rd[ST_PIN_EN_BIT] = pin_en_q;
  end

  // Hardware guard: pin low with enable set locks the status register
  assign status_open = latch_q & ~(pin_en_q & ~pins_s.wp_n);

  // Guarded range test; a page never straddles a range boundary
  always_comb begin
    case (guard_q)
      GUARD_NONE: page_guarded = 1'b0;
      GUARD_QUARTER: page_guarded = addr_q[12:0] >= GUARD_QUARTER_BASE;
      GUARD_HALF: page_guarded = addr_q[12:0] >= GUARD_HALF_BASE;
      default: page_guarded = 1'b1;
    endcase
  end

  // Transaction sequencer: phase, bit count, input shift and address
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      phase_q <= PH_IDLE;
      bit_cnt_q <= 3'h0;
      shift_q <= 8'h00;
      cmd_q <= 8'h00;
      addr_hi_done_q <= 1'b0;
      addr_q <= 16'h0000;
      have_byte_q <= 1'b0;
      stat_data_q <= 8'h00;
    end else if (cs_fall) begin
      // New transaction: opcode comes first
      phase_q <= PH_OPCODE;
      bit_cnt_q <= 3'h0;
      addr_hi_done_q <= 1'b0;
      have_byte_q <= 1'b0;
    end else if (cs_rise) begin
      // End actions are taken from the phase left behind
      phase_q <= PH_IDLE;
    end else if (sck_rise) begin
      bit_cnt_q <= bit_cnt_q + 3'h1;
      shift_q <= in_byte;
      case (phase_q)
        PH_OPCODE: begin
          if (byte_done) begin
            cmd_q <= in_byte;
            if (busy_q && in_byte != OP_RD_STATUS) begin
              phase_q <= PH_IDLE;
            end else begin
              case (in_byte)
                OP_SET_LATCH: phase_q <= PH_CMD_END;
                OP_CLR_LATCH: phase_q <= PH_CMD_END;
                OP_RD_STATUS: phase_q <= PH_STAT_OUT;
                // Writes without the latch are dropped at once
                OP_WR_STATUS: begin
                  phase_q <= latch_q ? PH_STAT_IN : PH_IDLE;
                end
                OP_RD_ARRAY: phase_q <= PH_ADDR;
                OP_WR_ARRAY: begin
                  phase_q <= latch_q ? PH_ADDR : PH_IDLE;
                end
                default: phase_q <= PH_IDLE;
              endcase
            end
          end
        end
        PH_CMD_END: begin
          // Extra clocks spoil a latch command
          phase_q <= PH_IDLE;
        end
        PH_ADDR: begin
          addr_q <= {addr_q[14:0], pins_s.si};
          if (byte_done) begin
            addr_hi_done_q <= 1'b1;
            if (addr_hi_done_q) begin
              phase_q <= (cmd_q == OP_RD_ARRAY) ? PH_ARRAY_OUT : PH_DATA_IN;
            end
          end
        end
        PH_DATA_IN: begin
          if (byte_done) begin
            have_byte_q <= 1'b1;
            // Only the column advances, wrapping inside the page
            addr_q[COL_BITS-1:0] <= addr_q[COL_BITS-1:0] + 6'h01;
          end
        end
        PH_STAT_IN: begin
          if (byte_done) begin
            have_byte_q <= 1'b1;
            stat_data_q <= in_byte;
          end
        end
        default: begin
          // Output phases and idle take nothing from the input
        end
      endcase
    end else if (sck_fall && phase_q == PH_ARRAY_OUT && out_cnt_q == 3'h7) begin
      // Last bit of a byte is out: step to the next location
      addr_q[12:0] <= addr_q[12:0] + 13'h0001;
    end
  end

  // Page buffer loading; kept intact until programming has finished
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      page_valid_q <= '0;
    end else if (cs_fall && !busy_q) begin
      page_valid_q <= '0;
    end else if (byte_done && phase_q == PH_DATA_IN) begin
      page_valid_q[addr_q[COL_BITS-1:0]] <= 1'b1;
    end
  end

  // Page buffer data has no reset; the valid mask covers it
  always_ff @(posedge clk_i) begin
    if (byte_done && phase_q == PH_DATA_IN) begin
      page_buf_q[addr_q[COL_BITS-1:0]] <= in_byte;
    end
  end

  // Status fields, write latch and the self-timed programming cycle
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      latch_q <= 1'b0;
      guard_q <= GUARD_RESET;
      pin_en_q <= PIN_EN_RESET;
      busy_q <= 1'b0;
      prog_status_q <= 1'b0;
      prog_page_q <= '0;
      timer_q <= 32'h0000_0000;
    end else if (busy_q) begin
      // Commands cannot reach here while busy, so only the timer runs
      if (prog_end) begin
        busy_q <= 1'b0;
        latch_q <= 1'b0;
        if (prog_status_q) begin
          // Only the writable status bits change
          pin_en_q <= stat_data_q[ST_PIN_EN_BIT];
          guard_q <= {stat_data_q[ST_GUARD_HI_BIT],
                      stat_data_q[ST_GUARD_LO_BIT]};
        end
      end else begin
        timer_q <= timer_q + 32'h0000_0001;
      end
    end else if (cs_rise) begin
      case (phase_q)
        PH_CMD_END: begin
          latch_q <= (cmd_q == OP_SET_LATCH);
        end
        PH_STAT_IN: begin
          // Pin sampled at the very end, so a late pin drop still refuses
          if (have_byte_q && status_open) begin
            busy_q <= 1'b1;
            prog_status_q <= 1'b1;
            timer_q <= 32'h0000_0000;
          end
        end
        PH_DATA_IN: begin
          if (have_byte_q && latch_q && !page_guarded) begin
            busy_q <= 1'b1;
            prog_status_q <= 1'b0;
            prog_page_q <= addr_q[ADDR_BITS-1:COL_BITS];
            timer_q <= 32'h0000_0000;
          end
        end
        default: begin
          // Reads leave the status untouched
        end
      endcase
    end
  end

  assign prog_end = busy_q & (timer_q == 32'(WRITE_CYCLES_P - 1));

  // Array commit at the end of the cycle; the array itself has no reset
  always_ff @(posedge clk_i) begin
    if (prog_end && !prog_status_q) begin
      for (int i = 0; i < PAGE_BYTES; i++) begin
        if (page_valid_q[i]) begin
          mem_q[{prog_page_q, COL_BITS'(i)}] <= page_buf_q[i];
        end
      end
    end
  end

  // Live source for the next output byte
  assign out_src = (phase_q == PH_ARRAY_OUT) ? mem_q[addr_q[12:0]] : status_rd;

  // Output shifter: a new bit on every usable falling edge in the status or array read phase
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      out_shift_q <= 8'h00;
      out_cnt_q <= 3'h0;
      out_started_q <= 1'b0;
      so_q <= 1'b0;
    end else if (cs_fall || cs_rise) begin
      out_cnt_q <= 3'h0;
      out_started_q <= 1'b0;
    end else if (sck_fall && (phase_q == PH_ARRAY_OUT ||
                              phase_q == PH_STAT_OUT)) begin
      out_started_q <= 1'b1;
      out_cnt_q <= out_cnt_q + 3'h1;
      if (out_cnt_q == 3'h0) begin
        // Status is re-read per byte so polling sees busy drop
        so_q <= out_src[7];
        out_shift_q <= {out_src[6:0], 1'b0};
      end else begin
        so_q <= out_shift_q[7];
        out_shift_q <= {out_shift_q[6:0], 1'b0};
      end
    end
  end

  // Output enable: off when deselected or paused
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      so_oe_q <= 1'b0;
    end else begin
      so_oe_q <= out_started_q & selected;
    end
  end

  assign so_o = so_q;
  assign so_oe_o = so_oe_q;
  assign busy_o = busy_q;

endmodule : secc_core

`default_nettype wire

//--- src/secc_pkg.sv
// Shared constants and types of the serial EEPROM command core.
// Assumes a single 40 MHz system clock that samples every pin.
`default_nettype none

package secc_pkg;

  // System clock and write cycle timing
  localparam int unsigned CLK_HZ = 40_000_000; // System clock rate
  localparam int unsigned WRITE_TIME_MS = 5; // Longest write cycle time
  // Longest time, so the cycle count rounds down
  localparam int unsigned WRITE_CYCLES = WRITE_TIME_MS * (CLK_HZ / 1000);

  // Array geometry
  localparam int unsigned ADDR_BITS = 13; // Significant address bits
  localparam int unsigned PAGE_BYTES = 64; // Page buffer depth
  localparam int unsigned COL_BITS = 6; // In-page address bits

  // Instruction opcodes
  localparam logic [7:0] OP_SET_LATCH = 8'h06; // cmd_set_write_latch
  localparam logic [7:0] OP_CLR_LATCH = 8'h04; // cmd_clear_write_latch
  localparam logic [7:0] OP_RD_STATUS = 8'h05; // cmd_read_status
  localparam logic [7:0] OP_WR_STATUS = 8'h01; // cmd_write_status
  localparam logic [7:0] OP_RD_ARRAY = 8'h03; // Array read
  localparam logic [7:0] OP_WR_ARRAY = 8'h02; // Array write

  // Status register field positions
  localparam int unsigned ST_BUSY_BIT = 0;
  localparam int unsigned ST_LATCH_BIT = 1;
  localparam int unsigned ST_GUARD_LO_BIT = 2;
  localparam int unsigned ST_GUARD_HI_BIT = 3;
  localparam int unsigned ST_PIN_EN_BIT = 7;

  // Reset values of the status fields
  localparam logic [1:0] GUARD_RESET = 2'h0;
  localparam logic PIN_EN_RESET = 1'b0;

  // Lowest guarded address for each block guard setting
  localparam logic [12:0] GUARD_QUARTER_BASE = 13'h1800;
  localparam logic [12:0] GUARD_HALF_BASE = 13'h1000;
  localparam logic [1:0] GUARD_NONE = 2'h0;
  localparam logic [1:0] GUARD_QUARTER = 2'h1;
  localparam logic [1:0] GUARD_HALF = 2'h2;

  // Idle levels of the pins, used to reset the synchronisers
  localparam logic [4:0] PINS_IDLE = 5'h0b;

  // Pin bundle as it arrives from the package pins
  typedef struct packed {
    logic sck; // Serial clock
    logic cs_n; // Chip select, active low
    logic si; // Serial data in
    logic hold_n; // Pause input, active low
    logic wp_n; // Guard pin, active low
  } secc_pins_t;

  // Transaction phases
  typedef enum logic [2:0] {
    PH_IDLE = 3'b000,
    PH_OPCODE = 3'b001,
    PH_CMD_END = 3'b010,
    PH_ADDR = 3'b011,
    PH_DATA_IN = 3'b100,
    PH_STAT_IN = 3'b101,
    PH_ARRAY_OUT = 3'b110,
    PH_STAT_OUT = 3'b111
  } secc_phase_t;

endpackage : secc_pkg

`default_nettype wire

//--- src/secc_sync.sv
// Two-stage synchroniser for a group of asynchronous pin levels.
// Assumes the inputs are levels; the reset value is each pin's idle level.
`default_nettype none

module secc_sync #(
  parameter int unsigned WIDTH = 1, // Number of bits
  parameter logic [WIDTH-1:0] RESET_VAL = '0 // Level held under reset
) (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic [WIDTH-1:0] d_i,
  output logic [WIDTH-1:0] q_o
);

  // Width zero cannot be built
  if (WIDTH < 1) begin : g_bad_width
    $error("secc_sync: WIDTH must be at least 1");
  end

  // One independent two-flop chain per bit
  for (genvar b = 0; b < WIDTH; b++) begin : g_bit
    logic meta_q; // First stage, read only by the second
    logic sync_q; // Second stage, safe to use
    always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
        meta_q <= RESET_VAL[b];
        sync_q <= RESET_VAL[b];
      end else begin
        meta_q <= d_i[b];
        sync_q <= meta_q;
      end
    end
    assign q_o[b] = sync_q;
  end

endmodule : secc_sync

`default_nettype wire
